// ---- src/dplc_top.sv ----
`timescale 1ns/1ps
`include "dplc_defines.svh"

module dplc_top
  import dplc_pkg::*;
#(
  parameter int TIMEOUT_CYC     = 65536,
  parameter int OVR_TIMEOUT_CYC = 200000
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Shared single-wire pin
  input  wire logic        pinIn,
  output dplc_pin_type     pinDrv,
  // System side
  input  wire logic        hvPulse,
  input  wire logic        fusePinCfg,
  input  wire logic        keyValid,
  input  wire logic        accessTimeout,
  output logic             pinIsPort,
  output logic             sysResetReq,
  output logic             cpuHalt,
  output logic             portClkReq,
  output dplc_instr_type   instr,
  output logic             instrValid,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  // ************************************
  // Declarations
  // ************************************
  logic           pinMeta, pinSync, pinLast;
  logic           hvMeta, hvSync, hvLast;
  logic           fuseMeta, fuseSync;
  dplc_state_type state;
  logic [16:0]    cnt;
  logic [15:0]    phase;
  logic [3:0]     bitIdx;
  logic [1:0]     syncEdges;
  logic [12:0]    bitTime;
  logic [11:0]    shift;
  logic [16:0]    lowCnt;
  logic [16:0]    breakLen;
  logic [2:0]     errSig;
  logic [2:0]     guard;
  logic [1:0]     clkSel;
  logic           dataPend;
  logic [3:0]     csAddr;
  logic           csWr;
  logic [7:0]     csWrData;
  logic           pinOverride;
  logic           keyOk;
  logic [31:0]    ovrCnt;
  logic           fallEdge, hvEdge, linkUp, breakSeen;
  logic           busWr, disableReq, rxDone;
  logic [11:0]    frame;
  logic [7:0]     txByte;

  // Register read mux shared by the link and the bus
  function automatic logic [7:0] csRead(input logic [3:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      `DPLC_IDX_STATUS_A: v = {4'h0, pinIsPort, pinOverride, keyOk, cpuHalt};
      `DPLC_IDX_STATUS_B: v = {5'h00, errSig};
      `DPLC_IDX_CTRL_A:   v = {1'b0, clkSel, 2'h0, guard};
      default:            v = 8'h00;
    endcase
    return v;
  endfunction

  // Instruction byte decode; reserved size codes are flagged
  function automatic dplc_instr_type decodeInstr(input logic [7:0] b);
    dplc_instr_type d;
    d.op       = dplc_op_type'(b[`DPLC_OP_MSB:`DPLC_OP_LSB]);
    d.sizeA    = b[3:2];
    d.sizeB    = b[1:0];
    d.sel      = b[2];
    d.reserved = 1'b0;
    case (d.op)
      OP_DIRECT_LOAD, OP_DIRECT_STORE:
        d.reserved = (b[3:2] == 2'h3) | b[1];
      OP_INDIRECT_LOAD:
        d.reserved = b[1];
      OP_INDIRECT_STORE:
        d.reserved = (b[3:2] == 2'h3) | b[1];
      OP_KEY:
        d.reserved = b[1];
      default:
        d.reserved = 1'b0;
    endcase
    return d;
  endfunction

  // ************************************
  // Input synchronisers
  // ************************************
  // Pin, pulse detector and fuse strap all come from outside this clock
  always_ff @(posedge clk) begin
    pinMeta  <= pinIn;
    pinSync  <= pinMeta;
    pinLast  <= pinSync;
    hvMeta   <= hvPulse;
    hvSync   <= hvMeta;
    hvLast   <= hvSync;
    fuseMeta <= fusePinCfg;
    fuseSync <= fuseMeta;
  end

  // Events seen by several processes
  assign fallEdge   = pinLast & ~pinSync;
  assign hvEdge     = hvSync & ~hvLast;
  assign linkUp     = ~(state inside {ST_OFF, ST_STARTUP, ST_WAIT_START});
  assign breakLen   = {1'b0, bitTime, 3'h0} + {2'h0, bitTime, 2'h0};
  assign breakSeen  = linkUp & (lowCnt == breakLen);
  assign busWr      = avs_write & ~avs_waitrequest;
  assign disableReq = (csWr & (csAddr == `DPLC_IDX_CTRL_B)
                       & csWrData[`DPLC_DIS_BIT])
                    | (busWr & (avs_address == `DPLC_OFF_CTRL_B)
                       & avs_writedata[`DPLC_DIS_BIT]);
  assign rxDone     = (state == ST_RX) & (phase == 16'h0000)
                    & (bitIdx == `DPLC_LAST_BIT);
  assign frame      = {pinSync, shift[11:1]};
  assign txByte     = csRead(frame[4:1]);

  // ************************************
  // Break detector
  // ************************************
  // A low line longer than twelve bit times is a break, never a frame
  always_ff @(posedge clk) begin
    if (sys_rst | pinSync | pinDrv.oe) begin
      lowCnt <= 17'h00000;
    end else if (lowCnt != breakLen) begin
      lowCnt <= lowCnt + 17'h00001;
    end
  end

  // ************************************
  // Link state machine
  // ************************************
  always_ff @(posedge clk) begin
    instrValid <= 1'b0;
    csWr       <= 1'b0;
    if (sys_rst) begin
      state      <= ST_OFF;
      pinDrv     <= '0;
      portClkReq <= 1'b0;
      cnt        <= 17'h00000;
      phase      <= 16'h0000;
      bitIdx     <= 4'h0;
      syncEdges  <= 2'h0;
      bitTime    <= `DPLC_BIT_RST;
      shift      <= 12'h000;
      errSig     <= `DPLC_ERR_NONE;
      dataPend   <= 1'b0;
      csAddr     <= 4'h0;
      csWrData   <= 8'h00;
      instr      <= '0;
    end else if (disableReq) begin
      state      <= ST_OFF;
      pinDrv     <= '0;
      portClkReq <= 1'b0;
      errSig     <= `DPLC_ERR_NONE;
      dataPend   <= 1'b0;
      bitTime    <= `DPLC_BIT_RST;
    end else if (breakSeen) begin
      state    <= ST_WAIT_SYNC;
      pinDrv   <= '0;
      dataPend <= 1'b0;
      bitTime  <= `DPLC_BIT_RST;
    end else if (linkUp & accessTimeout & (state != ST_ERROR)) begin
      state  <= ST_ERROR;
      pinDrv <= '0;
      errSig <= `DPLC_ERR_ACCESS;
    end else begin
      unique case (state)
        ST_OFF: begin
          // Falling edge only: a line still low after a self-disable
          // must not restart the port by itself
          if (pinIsPort & fallEdge) begin
            state      <= ST_STARTUP;
            pinDrv     <= '{out: 1'b0, oe: 1'b1};
            portClkReq <= 1'b1;
            cnt        <= 17'h00000;
          end
        end
        ST_STARTUP: begin
          cnt <= cnt + 17'h00001;
          if (cnt[15:0] == `DPLC_STARTUP_CYC - 16'h0001) begin
            state  <= ST_WAIT_START;
            pinDrv <= '0;
            cnt    <= 17'h00000;
          end
        end
        ST_WAIT_START: begin
          if (fallEdge) begin
            state     <= ST_SYNC;
            cnt       <= 17'h00001;
            syncEdges <= 2'h0;
          end else if (cnt == 17'(TIMEOUT_CYC - 1)) begin
            state      <= ST_OFF;
            portClkReq <= 1'b0;
          end else begin
            cnt <= cnt + 17'h00001;
          end
        end
        ST_WAIT_SYNC: begin
          if (fallEdge) begin
            state     <= ST_SYNC;
            cnt       <= 17'h00001;
            syncEdges <= 2'h0;
          end
        end
        ST_SYNC: begin
          // 0x55 gives four more falling edges, two bit times apart, the last eight bit times after the start;
          // the start edge counts as cycle one so the rate is not short
          if (~cnt[16]) begin
            cnt <= cnt + 17'h00001;
          end
          if (fallEdge) begin
            syncEdges <= syncEdges + 2'h1;
            if (syncEdges == 2'h3) begin
              if (cnt[16] | (cnt[15:3] < `DPLC_MIN_BIT_CYC)) begin
                state      <= ST_OFF;
                portClkReq <= 1'b0;
              end else begin
                state   <= ST_WAIT_BYTE;
                bitTime <= cnt[15:3];
              end
            end
          end
        end
        ST_WAIT_BYTE: begin
          if (fallEdge) begin
            state  <= ST_RX;
            phase  <= {4'h0, bitTime[12:1]};
            bitIdx <= 4'h0;
          end
        end
        ST_RX: begin
          if (phase != 16'h0000) begin
            phase <= phase - 16'h0001;
          end else begin
            shift  <= frame;
            bitIdx <= bitIdx + 4'h1;
            phase  <= {3'h0, bitTime} - 16'h0001;
            if (rxDone) begin
              if (frame[0] | ~frame[10] | ~frame[11]) begin
                state  <= ST_ERROR;
                errSig <= `DPLC_ERR_FRAME;
              end else if (^frame[9:1]) begin
                state  <= ST_ERROR;
                errSig <= `DPLC_ERR_PARITY;
              end else if (dataPend) begin
                // Data byte of a control store lands in the registers
                dataPend <= 1'b0;
                csWr     <= 1'b1;
                csWrData <= frame[8:1];
                state    <= ST_WAIT_SYNC;
              end else if (frame[8:6] == OP_CS_LOAD) begin
                state  <= ST_GUARD;
                shift  <= {2'h3, ^txByte, txByte, 1'b0};
                phase  <= {3'h0, bitTime} - 16'h0001;
                bitIdx <= 4'h0;
              end else if (frame[8:6] == OP_CS_STORE) begin
                csAddr   <= frame[4:1];
                dataPend <= 1'b1;
                state    <= ST_WAIT_BYTE;
              end else begin
                // System-space and key work is done outside this block
                instr      <= decodeInstr(frame[8:1]);
                instrValid <= 1'b1;
                state      <= ST_WAIT_SYNC;
              end
            end
          end
        end
        ST_GUARD: begin
          // Idle bits are counted at the measured rate before turning
          if (phase != 16'h0000) begin
            phase <= phase - 16'h0001;
          end else if (bitIdx == {1'b0, guard}) begin
            state  <= ST_TX;
            pinDrv <= '{out: 1'b0, oe: 1'b1};
            phase  <= {3'h0, bitTime} - 16'h0001;
            bitIdx <= 4'h0;
          end else begin
            bitIdx <= bitIdx + 4'h1;
            phase  <= {3'h0, bitTime} - 16'h0001;
          end
        end
        ST_TX: begin
          if ((phase == {4'h0, bitTime[12:1]}) & (pinSync != shift[0])) begin
            state  <= ST_ERROR;
            errSig <= `DPLC_ERR_CONTEND;
            pinDrv <= '0;
          end else if (phase != 16'h0000) begin
            phase <= phase - 16'h0001;
          end else if (bitIdx == `DPLC_LAST_BIT) begin
            state  <= ST_WAIT_SYNC;
            pinDrv <= '0;
          end else begin
            shift      <= {1'b1, shift[11:1]};
            pinDrv.out <= shift[1];
            bitIdx     <= bitIdx + 4'h1;
            phase      <= {3'h0, bitTime} - 16'h0001;
          end
        end
        ST_ERROR: begin
          pinDrv <= '0;
        end
      endcase
    end
  end

  // ************************************
  // Control registers
  // ************************************
  // Link store and bus write share these; the bus wins a same-cycle tie
  always_ff @(posedge clk) begin
    if (sys_rst | disableReq) begin
      guard  <= `DPLC_GUARD_RST;
      clkSel <= `DPLC_CLKSEL_RST;
    end else begin
      if (breakSeen) begin
        clkSel <= `DPLC_CLKSEL_RST;
      end else if (csWr & (csAddr == `DPLC_IDX_CTRL_A)) begin
        clkSel <= csWrData[`DPLC_CLKSEL_MSB:`DPLC_CLKSEL_LSB];
      end
      if (csWr & (csAddr == `DPLC_IDX_CTRL_A)) begin
        guard <= csWrData[`DPLC_GUARD_MSB:`DPLC_GUARD_LSB];
      end
      if (busWr & (avs_address == `DPLC_OFF_CTRL_A)) begin
        guard <= avs_writedata[`DPLC_GUARD_MSB:`DPLC_GUARD_LSB];
        if (~breakSeen) begin
          clkSel <= avs_writedata[`DPLC_CLKSEL_MSB:`DPLC_CLKSEL_LSB];
        end
      end
    end
  end

  // ************************************
  // Pin override, halt and system reset
  // ************************************
  // The override survives everything except power-on reset and expiry
  always_ff @(posedge clk) begin
    sysResetReq <= 1'b0;
    if (sys_rst) begin
      pinOverride <= 1'b0;
      cpuHalt     <= 1'b0;
      keyOk       <= 1'b0;
      ovrCnt      <= 32'h00000000;
      pinIsPort   <= 1'b0;
    end else begin
      pinIsPort <= fuseSync | pinOverride;
      if (hvEdge) begin
        pinOverride <= 1'b1;
        sysResetReq <= 1'b1;
        cpuHalt     <= 1'b1;
        keyOk       <= 1'b0;
        ovrCnt      <= 32'h00000000;
      end else if (disableReq) begin
        sysResetReq <= 1'b1;
        cpuHalt     <= 1'b0;
        keyOk       <= 1'b0;
      end else if (keyValid) begin
        keyOk   <= 1'b1;
        cpuHalt <= 1'b0;
      end else if (cpuHalt) begin
        if (ovrCnt == 32'(OVR_TIMEOUT_CYC - 1)) begin
          sysResetReq <= 1'b1;
          cpuHalt     <= 1'b0;
          pinOverride <= 1'b0;
        end else begin
          ovrCnt <= ovrCnt + 32'h00000001;
        end
      end
    end
  end

  // ************************************
  // Avalon-MM slave
  // ************************************
  // Fixed one wait cycle; unmapped reads return zero, writes are dropped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else if (avs_waitrequest & (avs_read | avs_write)) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= 32'h00000000;
      if (avs_read & (avs_address[1:0] == 2'h0)) begin
        avs_readdata <= {24'h000000, csRead({2'h0, avs_address[3:2]})};
      end
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // ************************************
  // Assertions
  // ************************************
  logic [19:0] guardCnt;
  logic [19:0] guardLen;
  assign guardLen = 20'({17'h00000, guard} + 20'h00001) * {7'h00, bitTime};
  always_ff @(posedge clk) begin
    guardCnt <= (state == ST_GUARD) ? guardCnt + 20'h00001 : 20'h00000;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence hvTaken;
    pinOverride && sysResetReq && cpuHalt ##1 pinIsPort;
  endsequence

  startup_timeout_a: assert property (
    state == ST_WAIT_START && cnt == 17'(TIMEOUT_CYC - 1) && !fallEdge
    && !disableReq && !accessTimeout |=> state == ST_OFF && !portClkReq)
    else $error("start bit timeout did not disable port");
  sync_reject_a: assert property (
    state == ST_SYNC && fallEdge && syncEdges == 2'h3 && !disableReq
    && (cnt[16] || cnt[15:3] < `DPLC_MIN_BIT_CYC) |=> state == ST_OFF)
    else $error("bad synchronisation length accepted");
  disable_reset_a: assert property (
    disableReq && !hvEdge |=> sysResetReq && state == ST_OFF)
    else $error("disable bit did not reset and disable");
  run_after_dis_a: assert property (
    disableReq && !hvEdge |=> !cpuHalt && !portClkReq && !keyOk
    && guard == `DPLC_GUARD_RST)
    else $error("disable left processor halted or settings kept");
  hv_override_a: assert property (
    hvEdge |=> hvTaken)
    else $error("pulse did not select port function");
  ovr_expire_a: assert property (
    cpuHalt && ovrCnt == 32'(OVR_TIMEOUT_CYC - 1) && !keyValid && !hvEdge
    && !disableReq |=> !pinOverride && sysResetReq && !cpuHalt)
    else $error("override timeout did not reset");
  error_hold_a: assert property (
    state == ST_ERROR && !breakSeen && !disableReq |=> state == ST_ERROR)
    else $error("error state left without break");
  parity_err_a: assert property (
    rxDone && !frame[0] && frame[10] && frame[11] && ^frame[9:1]
    && !disableReq && !breakSeen && !accessTimeout
    |=> state == ST_ERROR && errSig == `DPLC_ERR_PARITY)
    else $error("parity error not reported");
  guard_idle_a: assert property (
    $rose(state == ST_TX) |-> guardCnt == guardLen && pinDrv.oe
    && !pinDrv.out)
    else $error("guard idle length wrong before start bit");
  break_clk_a: assert property (
    breakSeen && !disableReq |=> clkSel == `DPLC_CLKSEL_RST
    && state == ST_WAIT_SYNC)
    else $error("break did not restore defaults");

endmodule

// ---- src/dplc_defines.svh ----
`ifndef DPLC_DEFINES_SVH
`define DPLC_DEFINES_SVH

// ***********************************
// Register indices and byte offsets
// ***********************************
`define DPLC_IDX_STATUS_A   4'h0
`define DPLC_IDX_STATUS_B   4'h1
`define DPLC_IDX_CTRL_A     4'h2
`define DPLC_IDX_CTRL_B     4'h3
`define DPLC_OFF_STATUS_A   4'h0
`define DPLC_OFF_STATUS_B   4'h4
`define DPLC_OFF_CTRL_A     4'h8
`define DPLC_OFF_CTRL_B     4'hc

// ***********************************
// Field positions and reset values
// ***********************************
`define DPLC_GUARD_MSB      2
`define DPLC_GUARD_LSB      0
`define DPLC_CLKSEL_MSB     6
`define DPLC_CLKSEL_LSB     5
`define DPLC_DIS_BIT        2
`define DPLC_OP_MSB         7
`define DPLC_OP_LSB         5
`define DPLC_GUARD_RST      3'h1
`define DPLC_CLKSEL_RST     2'h3

// ***********************************
// Timing counts and error codes
// ***********************************
`define DPLC_STARTUP_CYC    16'h0040
`define DPLC_MIN_BIT_CYC    13'h0008
`define DPLC_BIT_RST        13'h07d0
`define DPLC_LAST_BIT       4'hb
`define DPLC_ERR_NONE       3'h0
`define DPLC_ERR_PARITY     3'h1
`define DPLC_ERR_FRAME      3'h2
`define DPLC_ERR_CONTEND    3'h3
`define DPLC_ERR_ACCESS     3'h4

`endif

// ---- src/dplc_pkg.sv ----
package dplc_pkg;

  // One-hot link states
  typedef enum logic [9:0] {
    ST_OFF        = 10'h001,
    ST_STARTUP    = 10'h002,
    ST_WAIT_START = 10'h004,
    ST_SYNC       = 10'h008,
    ST_WAIT_SYNC  = 10'h010,
    ST_WAIT_BYTE  = 10'h020,
    ST_RX         = 10'h040,
    ST_GUARD      = 10'h080,
    ST_TX         = 10'h100,
    ST_ERROR      = 10'h200
  } dplc_state_type;

  // Opcode field of an instruction byte
  typedef enum logic [2:0] {
    OP_DIRECT_LOAD    = 3'h0,
    OP_INDIRECT_LOAD  = 3'h1,
    OP_DIRECT_STORE   = 3'h2,
    OP_INDIRECT_STORE = 3'h3,
    OP_CS_LOAD        = 3'h4,
    OP_REPEAT         = 3'h5,
    OP_CS_STORE       = 3'h6,
    OP_KEY            = 3'h7
  } dplc_op_type;

  // Decoded instruction handed to the system side
  typedef struct packed {
    dplc_op_type op;
    logic [1:0]  sizeA;
    logic [1:0]  sizeB;
    logic        sel;
    logic        reserved;
  } dplc_instr_type;

  // Drive of the shared pin
  typedef struct packed {
    logic out;
    logic oe;
  } dplc_pin_type;

endpackage

// ---- tb/dplc_prog_model.sv ----
`timescale 1ns/1ps
// ***********************************
// Single-wire programmer model
// ***********************************
module dplc_prog_model
  import dplc_pkg::*;
(
  // Clock
  input  wire logic   clk,
  // Shared pin
  input  dplc_pin_type pinDrv,
  output logic         pinLevel
);
  logic progLow = 1'b0;
  // Programmer only pulls low; pull-up holds the idle wire high
  assign pinLevel = progLow ? 1'b0 : (pinDrv.oe ? pinDrv.out : 1'b1);
  // Hold the wire low for n cycles, used for enable and break
  task automatic pulse_low(input int n);
    progLow <= 1'b1;
    repeat (n) @(posedge clk);
    progLow <= 1'b0;
  endtask
  // One break, sent while the device is idle or in error; a second
  // short one would start a sync measurement at the reset rate
  task automatic brk(input int bt);
    pulse_low(13 * bt);
    repeat (2 * bt) @(posedge clk);
  endtask
  // Poll until the device lets the wire go high again
  task automatic wait_high(output logic ok);
    int n;
    n = 0;
    while (pinLevel !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    ok = (pinLevel === 1'b1);
  endtask
  // One frame: start, data LSB first, even parity, two stops
  task automatic send(input logic [7:0] b, input int bt,
                      input logic bad = 1'b0);
    logic [11:0] f;
    f = {2'b11, ^b ^ bad, b, 1'b0};
    for (int i = 0; i < 12; i++) begin
      progLow <= ~f[i];
      repeat (bt) @(posedge clk);
    end
  endtask
  // Count idle cycles up to the start bit, then sample mid-bit
  task automatic recv(input int bt, output logic [7:0] b, output int idle);
    idle = 0;
    while (pinLevel === 1'b1 && idle < 4000) begin
      @(posedge clk);
      idle++;
    end
    repeat (bt / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bt) @(posedge clk);
      b[i] = pinLevel;
    end
    // Let parity and stop bits pass before the wire is touched again
    repeat (4 * bt) @(posedge clk);
  endtask
endmodule

// ---- tb/dplc_top_tb.sv ----
`timescale 1ns/1ps
// ***********************************
// Link control bench
// ***********************************
module dplc_top_tb import dplc_pkg::*;;
  localparam int BT = 16;
  logic           clk, sys_rst, pinLevel, hvPulse, fusePinCfg;
  logic           keyValid, accessTimeout, pinIsPort, sysResetReq;
  logic           cpuHalt, portClkReq, instrValid, ok;
  logic           avs_read, avs_write, avs_waitrequest;
  logic [3:0]     avs_address;
  logic [31:0]    avs_writedata, avs_readdata, q;
  logic [7:0]     rx;
  dplc_pin_type   pinDrv;
  dplc_instr_type instr;
  dplc_op_type    lastOp;
  int             n_mismatch, checks, nRst, nInstr, idle;
  logic [2:0]     ops [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
  dplc_top #(.TIMEOUT_CYC(200), .OVR_TIMEOUT_CYC(300)) dplc_top_inst (
    .clk(clk), .sys_rst(sys_rst), .pinIn(pinLevel), .pinDrv(pinDrv),
    .hvPulse(hvPulse), .fusePinCfg(fusePinCfg), .keyValid(keyValid),
    .accessTimeout(accessTimeout), .pinIsPort(pinIsPort),
    .sysResetReq(sysResetReq), .cpuHalt(cpuHalt), .portClkReq(portClkReq),
    .instr(instr), .instrValid(instrValid), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  dplc_prog_model dplc_prog_model_inst (
    .clk(clk), .pinDrv(pinDrv), .pinLevel(pinLevel));
  // Clock at 20 MHz
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Count reset requests and keep the last decoded opcode
  always @(posedge clk) begin
    if (sysResetReq === 1'b1) nRst++;
    if (instrValid === 1'b1) begin
      lastOp = instr.op;
      nInstr++;
    end
  end
  task automatic end_sim();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bus cycle held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 100) chk("busTimeout", 0, 1);
    if (n >= 100) end_sim();
    @(posedge clk);
  endtask
  // Sync, then read back status register B over the wire
  task automatic control_status_load_instr_status(input logic [7:0] e, input logic cg);
    dplc_prog_model_inst.send(8'h55, BT);
    dplc_prog_model_inst.send(8'h81, BT);
    dplc_prog_model_inst.recv(BT, rx, idle);
    chk("port_status_b", e, rx);
    chk("replySeen", 1, idle < 4000);
    if (cg) chk("guardIdle", 1, idle >= 3 * BT && idle < 4 * BT + 8);
  endtask
  initial begin
    {hvPulse, keyValid, accessTimeout, avs_read, avs_write} = 5'h00;
    {avs_address, avs_writedata} = 36'h0;
    fusePinCfg = 1'b1;
    sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    bus(0, 4'h8, 0); chk("port_control_a", 32'h61, q);
    bus(0, 4'h6, 0); chk("unmapped", 0, q);
    bus(1, 4'h8, 32'h23);
    dplc_prog_model_inst.pulse_low(8);
    chk("clkReq", 1, portClkReq);
    dplc_prog_model_inst.wait_high(ok); chk("released", 1, ok);
    dplc_prog_model_inst.send(8'h55, BT);
    dplc_prog_model_inst.send(8'h81, BT);
    dplc_prog_model_inst.recv(BT, rx, idle);
    chk("firstReply", 0, rx);
    chk("guardIdle", 1, idle >= 3 * BT && idle < 4 * BT + 8);
    foreach (ops[i]) begin
      dplc_prog_model_inst.brk(BT);
      dplc_prog_model_inst.send(8'h55, BT);
      dplc_prog_model_inst.send({ops[i], 5'h00}, BT);
      chk("opcode", ops[i], lastOp);
    end
    bus(0, 4'h8, 0); chk("clkSelBreak", 32'h63, q);
    accessTimeout <= 1'b1;
    @(posedge clk);
    accessTimeout <= 1'b0;
    nInstr = 0;
    dplc_prog_model_inst.send(8'h55, BT);
    dplc_prog_model_inst.send(8'h40, BT);
    chk("ignored", 0, nInstr);
    dplc_prog_model_inst.brk(BT);
    control_status_load_instr_status(8'h04, 1'b1);
    dplc_prog_model_inst.send(8'h55, BT);
    dplc_prog_model_inst.send(8'h40, BT, 1'b1);
    dplc_prog_model_inst.brk(BT);
    control_status_load_instr_status(8'h01, 1'b0);
    dplc_prog_model_inst.send(8'h55, BT);
    dplc_prog_model_inst.send(8'hc2, BT);
    dplc_prog_model_inst.send(8'h02, BT);
    bus(0, 4'h8, 0); chk("ctrlALink", 32'h02, q);
    nRst = 0;
    bus(1, 4'hc, 32'h04);
    repeat (3) @(posedge clk);
    chk("disRst", 1, nRst); chk("disClk", 0, portClkReq);
    bus(0, 4'h4, 0); chk("sigClr", 0, q);
    bus(0, 4'h8, 0); chk("ctrlAClr", 32'h61, q);
    dplc_prog_model_inst.pulse_low(8);
    dplc_prog_model_inst.wait_high(ok); chk("released", 1, ok);
    repeat (260) @(posedge clk);
    chk("startTimeout", 0, portClkReq);
    dplc_prog_model_inst.pulse_low(8);
    dplc_prog_model_inst.wait_high(ok); chk("released", 1, ok);
    dplc_prog_model_inst.send(8'h55, 4);
    repeat (5) @(posedge clk);
    chk("badSync", 0, portClkReq);
    fusePinCfg <= 1'b0;
    repeat (6) @(posedge clk);
    // First pass lets the override time out, second sends a key
    for (int k = 0; k < 2; k++) begin
      nRst = 0;
      hvPulse <= 1'b1;
      repeat (8) @(posedge clk);
      hvPulse <= 1'b0;
      chk("hvPin", 1, pinIsPort); chk("hvRst", 1, nRst);
      chk("hvHalt", 1, cpuHalt);
      keyValid <= k[0];
      @(posedge clk);
      keyValid <= 1'b0;
      repeat (400) @(posedge clk);
      chk("keyRun", 0, cpuHalt); chk("ovrRst", 2 - k, nRst);
      chk("ovrKeep", k, pinIsPort);
    end
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    chk("porClr", 0, pinIsPort);
    end_sim();
  end
endmodule
